// *** src/nor_pins_pkg.sv ***
// Shared register map, field positions, reset values and timing counts for the flash pin block.
`default_nettype none
package nor_pins_pkg;
    // Register byte offsets on the Avalon-MM slave.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] LOCK_OFS   = 8'h08;
    localparam logic [7:0] WRCNT_OFS  = 8'h0C;

    // Fields of the enhanced configuration register.
    localparam int CTRL_WAIT_HIGH_BIT  = 0;
    localparam int CTRL_SLEEP_EN_BIT   = 1;
    localparam int CTRL_SLEEP_HIGH_BIT = 2;
    localparam logic [2:0] CTRL_RESET  = 3'h0;

    // Fields of the status register.
    localparam int STS_IN_RESET_BIT = 0;
    localparam int STS_BUSY_BIT     = 1;
    localparam int STS_SLEEP_BIT    = 2;
    localparam int STS_WP1_BIT      = 3;
    localparam int STS_WP2_BIT      = 4;
    localparam int STS_LOCK1_BIT    = 5;
    localparam int STS_LOCK2_BIT    = 6;
    localparam int STS_REFUSED_BIT  = 7;

    // Fields of the lock-down register.
    localparam int LOCK_SET_LSB       = 0;
    localparam int LOCK_UNLOCK_LSB    = 8;
    localparam int LOCK_CLR_REFUSED   = 16;
    localparam logic [1:0] LOCK_RESET = 2'h0;

    // Write counters: accepted in the low half, refused in the high half.
    localparam int CNT_W         = 16;
    localparam int CNT_REFUSED_LSB = 16;

    // Link-clock cycles of an internal write operation and of initial read latency.
    localparam int OP_CYCLES_DEF = 16;
    localparam int READ_LAT_DEF  = 3;
endpackage
`default_nettype wire

// *** src/nor_bit_sync.sv ***
// Two-flop level synchroniser for a group of independent bits.
`timescale 1ns/1ps
`default_nettype none
module nor_bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    always_comb
    begin
        d      = q;
        d.meta = d_i;
        d.sync = q.meta;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign q_o = q.sync;
endmodule
`default_nettype wire

// *** src/nor_link_core.sv ***
// Flash-side logic on the link clock: write acceptance, internal operation and the wait level.
`timescale 1ns/1ps
`default_nettype none
module nor_link_core #(
    parameter int OP_CYCLES = nor_pins_pkg::OP_CYCLES_DEF,
    parameter int READ_LAT  = nor_pins_pkg::READ_LAT_DEF
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic flash_rst_n_i,
    input  wire logic chip_en_n_i,
    input  wire logic out_en_n_i,
    input  wire logic write_en_n_i,
    input  wire logic sleep_i,
    input  wire logic wait_high_i,
    output logic      wait_o,
    output logic      busy_o,
    output logic      in_reset_o,
    output logic      accept_tog_o,
    output logic      refuse_tog_o,
    output logic      standby_o
);
    localparam int CW = $clog2(OP_CYCLES + 1);
    localparam int LW = $clog2(READ_LAT + 1);
    localparam logic [CW-1:0] OP_LAST  = CW'(OP_CYCLES - 1);
    localparam logic [LW-1:0] LAT_FULL = LW'(READ_LAT);

    typedef enum logic {ST_READY, ST_BUSY} op_state_t;

    typedef struct packed {
        op_state_t     state;
        logic [CW-1:0] op_cnt;
        logic [LW-1:0] lat_cnt;
        logic          we_prev;
        logic          wait_lvl;
        logic          acc_tog;
        logic          ref_tog;
        logic          in_reset;
        logic          standby;
    } core_state_t;

    core_state_t q;
    core_state_t d;

    logic write_strobe;
    logic read_on;
    logic data_valid;

    always_comb
    begin
        d            = q;
        // A write cycle starts on the falling write enable of a selected die.
        write_strobe = q.we_prev & ~write_en_n_i & ~chip_en_n_i;
        read_on      = ~chip_en_n_i & ~out_en_n_i;
        data_valid   = read_on & (q.lat_cnt == LAT_FULL) & flash_rst_n_i & ~sleep_i
                       & (q.state == ST_READY);
        d.we_prev    = write_en_n_i;
        d.in_reset   = ~flash_rst_n_i;
        d.standby    = chip_en_n_i | sleep_i;
        if (!flash_rst_n_i)
        begin
            // Abort whatever runs and fall back to the read state.
            d.state  = ST_READY;
            d.op_cnt = '0;
            if (write_strobe)
            begin
                d.ref_tog = ~q.ref_tog;
            end
        end
        else
        begin
            case (q.state)
                ST_READY:
                begin
                    if (write_strobe && sleep_i)
                    begin
                        d.ref_tog = ~q.ref_tog;
                    end
                    else if (write_strobe)
                    begin
                        d.acc_tog = ~q.acc_tog;
                        d.state   = ST_BUSY;
                        d.op_cnt  = OP_LAST;
                    end
                end
                ST_BUSY:
                begin
                    if (write_strobe)
                    begin
                        d.ref_tog = ~q.ref_tog;
                    end
                    if (q.op_cnt == '0)
                    begin
                        d.state = ST_READY;
                    end
                    else
                    begin
                        d.op_cnt = q.op_cnt - CW'(1);
                    end
                end
                default:
                begin
                    d.state = ST_READY;
                end
            endcase
        end
        if (!read_on)
        begin
            d.lat_cnt = '0;
        end
        else if (q.lat_cnt != LAT_FULL)
        begin
            d.lat_cnt = q.lat_cnt + LW'(1);
        end
        // The wait level marks invalid data, in the polarity that is configured.
        d.wait_lvl = data_valid ? ~wait_high_i : wait_high_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q         <= '0;
            q.we_prev <= 1'b1;
            q.standby <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign wait_o       = q.wait_lvl;
    assign busy_o       = (q.state == ST_BUSY);
    assign in_reset_o   = q.in_reset;
    assign accept_tog_o = q.acc_tog;
    assign refuse_tog_o = q.ref_tog;
    assign standby_o    = q.standby;
endmodule
`default_nettype wire

// *** src/nor_ctrl_pins.sv ***
// Top of the flash control-pin block: register slave, lock-down, deep sleep and link crossing.
`timescale 1ns/1ps
`default_nettype none
module nor_ctrl_pins #(
    parameter int OP_CYCLES = nor_pins_pkg::OP_CYCLES_DEF,
    parameter int READ_LAT  = nor_pins_pkg::READ_LAT_DEF
) (
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        LINK_CLK_I,
    input  wire logic [7:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    input  wire logic        FLASH_RST_N_I,
    input  wire logic        CHIP_EN_N_I,
    input  wire logic        OUT_EN_N_I,
    input  wire logic        WRITE_EN_N_I,
    input  wire logic        LOCKDOWN_PROTECT_DIE1_N_I,
    input  wire logic        LOCKDOWN_PROTECT_DIE2_N_I,
    input  wire logic        DEEP_SLEEP_REQUEST_I,
    output logic             WAIT_O,
    output logic             WAIT_OE_O,
    output logic             DATA_OE_O,
    output logic             STANDBY_O
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        wait_high;
        logic        sleep_en;
        logic        sleep_high;
        logic        sleep;
        logic [1:0]  lock;
        logic        unlock_refused;
        logic [nor_pins_pkg::CNT_W-1:0] acc_cnt;
        logic [nor_pins_pkg::CNT_W-1:0] ref_cnt;
        logic        acc_seen;
        logic        ref_seen;
    } regs_state_t;

    regs_state_t q;
    regs_state_t d;

    // Pins that reach the register clock domain.
    logic [2:0] pin_sync;
    logic       wp1_n;
    logic       wp2_n;
    logic       sleep_pin;

    // Link-domain reset, configuration and status crossings.
    logic       link_arst_n;
    logic [1:0] cfg_link;
    logic       link_wait;
    logic       link_busy;
    logic       link_in_reset;
    logic       link_acc_tog;
    logic       link_ref_tog;
    logic       link_standby;
    logic [3:0] sts_sync;

    logic        req;
    logic        wr_take;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [31:0] status_word;
    logic [1:0]  protect_high;
    logic [1:0]  unlock_req;
    logic        acc_evt;
    logic        ref_evt;

    // Expands Avalon byte enables into a bit mask.
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    nor_bit_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_i   (CLK_I),
        .arst_n_i(ARST_N_I),
        .d_i     ({DEEP_SLEEP_REQUEST_I, LOCKDOWN_PROTECT_DIE2_N_I, LOCKDOWN_PROTECT_DIE1_N_I}),
        .q_o     (pin_sync)
    );

    assign wp1_n     = pin_sync[0];
    assign wp2_n     = pin_sync[1];
    assign sleep_pin = pin_sync[2];

    // Reset for the link domain: asserted at once, released on the link clock.
    nor_bit_sync #(
        .WIDTH(1)
    ) u_link_rst (
        .clk_i   (LINK_CLK_I),
        .arst_n_i(ARST_N_I),
        .d_i     (1'b1),
        .q_o     (link_arst_n)
    );

    nor_bit_sync #(
        .WIDTH(2)
    ) u_cfg_sync (
        .clk_i   (LINK_CLK_I),
        .arst_n_i(link_arst_n),
        .d_i     ({q.wait_high, q.sleep}),
        .q_o     (cfg_link)
    );

    nor_link_core #(
        .OP_CYCLES(OP_CYCLES),
        .READ_LAT (READ_LAT)
    ) u_core (
        .clk_i        (LINK_CLK_I),
        .arst_n_i     (link_arst_n),
        .flash_rst_n_i(FLASH_RST_N_I),
        .chip_en_n_i  (CHIP_EN_N_I),
        .out_en_n_i   (OUT_EN_N_I),
        .write_en_n_i (WRITE_EN_N_I),
        .sleep_i      (cfg_link[0]),
        .wait_high_i  (cfg_link[1]),
        .wait_o       (link_wait),
        .busy_o       (link_busy),
        .in_reset_o   (link_in_reset),
        .accept_tog_o (link_acc_tog),
        .refuse_tog_o (link_ref_tog),
        .standby_o    (link_standby)
    );

    nor_bit_sync #(
        .WIDTH(4)
    ) u_sts_sync (
        .clk_i   (CLK_I),
        .arst_n_i(ARST_N_I),
        .d_i     ({link_ref_tog, link_acc_tog, link_busy, link_in_reset}),
        .q_o     (sts_sync)
    );

    // Pin-facing outputs. The drive enables follow the enables with no clock.
    assign WAIT_O    = link_wait;
    assign WAIT_OE_O = ~CHIP_EN_N_I & ~OUT_EN_N_I;
    assign DATA_OE_O = ~CHIP_EN_N_I & ~OUT_EN_N_I;
    assign STANDBY_O = link_standby;

    always_comb
    begin
        d            = q;
        req          = AVS_READ_I | AVS_WRITE_I;
        wr_take      = AVS_WRITE_I & q.ack;
        wmask        = be_mask(AVS_BYTEENABLE_I);
        wbits        = AVS_WRITEDATA_I & wmask;
        protect_high = {wp2_n, wp1_n};
        unlock_req   = '0;
        acc_evt      = sts_sync[2] ^ q.acc_seen;
        ref_evt      = sts_sync[3] ^ q.ref_seen;
        d.acc_seen   = sts_sync[2];
        d.ref_seen   = sts_sync[3];

        status_word = '0;
        status_word[nor_pins_pkg::STS_IN_RESET_BIT] = sts_sync[0];
        status_word[nor_pins_pkg::STS_BUSY_BIT]     = sts_sync[1];
        status_word[nor_pins_pkg::STS_SLEEP_BIT]    = q.sleep;
        status_word[nor_pins_pkg::STS_WP1_BIT]      = wp1_n;
        status_word[nor_pins_pkg::STS_WP2_BIT]      = wp2_n;
        status_word[nor_pins_pkg::STS_LOCK1_BIT]    = q.lock[0];
        status_word[nor_pins_pkg::STS_LOCK2_BIT]    = q.lock[1];
        status_word[nor_pins_pkg::STS_REFUSED_BIT]  = q.unlock_refused;

        // Deep sleep follows the pin only when enabled, in the chosen level.
        d.sleep = q.sleep_en & (sleep_pin == q.sleep_high);

        // One wait cycle per access; read data is registered during it.
        d.ack   = req & ~q.ack;
        d.rdata = '0;
        if (AVS_READ_I && !q.ack)
        begin
            if (AVS_ADDRESS_I == nor_pins_pkg::CTRL_OFS)
            begin
                d.rdata[nor_pins_pkg::CTRL_WAIT_HIGH_BIT]  = q.wait_high;
                d.rdata[nor_pins_pkg::CTRL_SLEEP_EN_BIT]   = q.sleep_en;
                d.rdata[nor_pins_pkg::CTRL_SLEEP_HIGH_BIT] = q.sleep_high;
            end
            else if (AVS_ADDRESS_I == nor_pins_pkg::STATUS_OFS)
            begin
                d.rdata = status_word;
            end
            else if (AVS_ADDRESS_I == nor_pins_pkg::LOCK_OFS)
            begin
                d.rdata[nor_pins_pkg::LOCK_SET_LSB +: 2] = q.lock;
            end
            else if (AVS_ADDRESS_I == nor_pins_pkg::WRCNT_OFS)
            begin
                d.rdata = {q.ref_cnt, q.acc_cnt};
            end
        end

        if (wr_take && AVS_ADDRESS_I == nor_pins_pkg::CTRL_OFS)
        begin
            if (wmask[nor_pins_pkg::CTRL_WAIT_HIGH_BIT])
            begin
                d.wait_high = wbits[nor_pins_pkg::CTRL_WAIT_HIGH_BIT];
            end
            if (wmask[nor_pins_pkg::CTRL_SLEEP_EN_BIT])
            begin
                d.sleep_en = wbits[nor_pins_pkg::CTRL_SLEEP_EN_BIT];
            end
            if (wmask[nor_pins_pkg::CTRL_SLEEP_HIGH_BIT])
            begin
                d.sleep_high = wbits[nor_pins_pkg::CTRL_SLEEP_HIGH_BIT];
            end
        end

        if (wr_take && AVS_ADDRESS_I == nor_pins_pkg::LOCK_OFS)
        begin
            unlock_req = wbits[nor_pins_pkg::LOCK_UNLOCK_LSB +: 2];
            if (wbits[nor_pins_pkg::LOCK_CLR_REFUSED])
            begin
                d.unlock_refused = 1'b0;
            end
            for (int i = 0; i < 2; i++)
            begin
                // Each die's unlock looks only at that die's protect input.
                if (unlock_req[i] && protect_high[i])
                begin
                    d.lock[i] = 1'b0;
                end
                else if (unlock_req[i])
                begin
                    d.unlock_refused = 1'b1;
                end
                if (wbits[nor_pins_pkg::LOCK_SET_LSB + i])
                begin
                    d.lock[i] = 1'b1;
                end
            end
        end

        // Writing the counter word clears it; an event in the same cycle still counts.
        if (wr_take && AVS_ADDRESS_I == nor_pins_pkg::WRCNT_OFS)
        begin
            d.acc_cnt = '0;
            d.ref_cnt = '0;
        end
        if (acc_evt)
        begin
            d.acc_cnt = (wr_take && AVS_ADDRESS_I == nor_pins_pkg::WRCNT_OFS) ?
                        nor_pins_pkg::CNT_W'(1) : q.acc_cnt + nor_pins_pkg::CNT_W'(1);
        end
        if (ref_evt)
        begin
            d.ref_cnt = (wr_take && AVS_ADDRESS_I == nor_pins_pkg::WRCNT_OFS) ?
                        nor_pins_pkg::CNT_W'(1) : q.ref_cnt + nor_pins_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            q            <= '0;
            q.wait_high  <= nor_pins_pkg::CTRL_RESET[nor_pins_pkg::CTRL_WAIT_HIGH_BIT];
            q.sleep_en   <= nor_pins_pkg::CTRL_RESET[nor_pins_pkg::CTRL_SLEEP_EN_BIT];
            q.sleep_high <= nor_pins_pkg::CTRL_RESET[nor_pins_pkg::CTRL_SLEEP_HIGH_BIT];
            q.lock       <= nor_pins_pkg::LOCK_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign AVS_READDATA_O    = q.rdata;
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~q.ack;
endmodule
`default_nettype wire

// *** verification/nor_ctrl_pins_monitor.sv ***
// Concurrent checks on the ports of the flash control-pin block.
`timescale 1ns/1ps
`default_nettype none
module nor_ctrl_pins_monitor (
    input wire logic        CLK_I,
    input wire logic        ARST_N_I,
    input wire logic        LINK_CLK_I,
    input wire logic [7:0]  AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0]  AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        FLASH_RST_N_I,
    input wire logic        CHIP_EN_N_I,
    input wire logic        OUT_EN_N_I,
    input wire logic        WRITE_EN_N_I,
    input wire logic        LOCKDOWN_PROTECT_DIE1_N_I,
    input wire logic        LOCKDOWN_PROTECT_DIE2_N_I,
    input wire logic        DEEP_SLEEP_REQUEST_I,
    input wire logic        WAIT_O,
    input wire logic        WAIT_OE_O,
    input wire logic        DATA_OE_O,
    input wire logic        STANDBY_O
);
    logic       wait_high_q;
    logic       sleep_en_q;
    logic       sleep_high_q;
    logic [3:0] prot_lo_q;
    logic [3:0] prot_hi_q;
    logic [4:0] sleep_cnt_q;
    logic       ctrl_wr;
    logic       sleep_on;
    assign ctrl_wr  = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0]
                      && AVS_ADDRESS_I == nor_pins_pkg::CTRL_OFS;
    assign sleep_on = sleep_en_q && (DEEP_SLEEP_REQUEST_I == sleep_high_q);
    // Shadow configuration and pin-age counters.
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            wait_high_q  <= 1'b0;
            sleep_en_q   <= 1'b0;
            sleep_high_q <= 1'b0;
            prot_lo_q    <= 4'h0;
            prot_hi_q    <= 4'h0;
            sleep_cnt_q  <= 5'h00;
        end
        else
        begin
            if (ctrl_wr)
            begin
                wait_high_q  <= AVS_WRITEDATA_I[nor_pins_pkg::CTRL_WAIT_HIGH_BIT];
                sleep_en_q   <= AVS_WRITEDATA_I[nor_pins_pkg::CTRL_SLEEP_EN_BIT];
                sleep_high_q <= AVS_WRITEDATA_I[nor_pins_pkg::CTRL_SLEEP_HIGH_BIT];
            end
            prot_lo_q   <= LOCKDOWN_PROTECT_DIE1_N_I ? 4'h0 : prot_lo_q + 4'(prot_lo_q != 4'hF);
            prot_hi_q   <= !LOCKDOWN_PROTECT_DIE1_N_I ? 4'h0 : prot_hi_q + 4'(prot_hi_q != 4'hF);
            sleep_cnt_q <= !sleep_on ? 5'h00 : sleep_cnt_q + 5'(sleep_cnt_q != 5'h1F);
        end
    end
    sequence unlock1_try;
        AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == nor_pins_pkg::LOCK_OFS
        && AVS_BYTEENABLE_I[1] && AVS_WRITEDATA_I[nor_pins_pkg::LOCK_UNLOCK_LSB]
        && !AVS_WRITEDATA_I[0];
    endsequence
    sequence reg_read(logic [7:0] ofs);
        AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == ofs;
    endsequence
    AST_WAIT_OE: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        WAIT_OE_O == (!CHIP_EN_N_I && !OUT_EN_N_I)) else $error("wait enable wrong");
    AST_DATA_OE: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        DATA_OE_O == (!OUT_EN_N_I && !CHIP_EN_N_I)) else $error("data enable wrong");
    AST_STANDBY_DESELECT: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        CHIP_EN_N_I |=> STANDBY_O) else $error("no standby when deselected");
    AST_RESET_WAIT: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        (!FLASH_RST_N_I && WAIT_OE_O) [*3] |-> WAIT_O == wait_high_q)
        else $error("wait valid during pin reset");
    AST_READ_LATENCY: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        $rose(WAIT_OE_O) ##1 WAIT_OE_O |-> WAIT_O == wait_high_q)
        else $error("wait valid before latency");
    AST_READ_VALID: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        (WAIT_OE_O && FLASH_RST_N_I && WRITE_EN_N_I && !sleep_en_q) [*8]
        |-> WAIT_O != wait_high_q) else $error("wait never shows valid");
    AST_UNLOCK_BLOCKED: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        unlock1_try ##0 prot_lo_q > 4'h4 ##[1:4] reg_read(nor_pins_pkg::STATUS_OFS)
        |-> AVS_READDATA_O[nor_pins_pkg::STS_REFUSED_BIT]) else $error("unlock not refused");
    AST_UNLOCK_ALLOWED: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        unlock1_try ##0 prot_hi_q > 4'h4 ##[1:4] reg_read(nor_pins_pkg::LOCK_OFS)
        |-> !AVS_READDATA_O[0]) else $error("unlock ignored");
    AST_SLEEP_ENTER: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        sleep_cnt_q == 5'h1F |-> STANDBY_O) else $error("deep sleep not entered");
endmodule
`default_nettype wire

// *** verification/flash_host_model.sv ***
// Behavioural host memory controller driving the flash control pins on the link clock.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    input  wire logic link_clk_i,
    output var logic  rst_n_o,
    output var logic  ce_n_o,
    output var logic  oe_n_o,
    output var logic  we_n_o
);
    initial
    begin
        rst_n_o = 1'b1;
        ce_n_o  = 1'b1;
        oe_n_o  = 1'b1;
        we_n_o  = 1'b1;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge link_clk_i);
    endtask
    task automatic drive(input logic rst_n, input logic ce_n, input logic oe_n);
        @(posedge link_clk_i);
        rst_n_o <= rst_n;
        ce_n_o  <= ce_n;
        oe_n_o  <= oe_n;
    endtask
    // Chip enable frames the strobe by one link edge each side.
    task automatic strobe();
        @(posedge link_clk_i);
        ce_n_o <= 1'b0;
        @(posedge link_clk_i);
        we_n_o <= 1'b0;
        @(posedge link_clk_i);
        we_n_o <= 1'b1;
        @(posedge link_clk_i);
        ce_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** verification/nor_flash_control_pins_test.sv ***
// Self-checking bench for the flash control-pin block.
`timescale 1ns/1ps
`default_nettype none
module nor_flash_control_pins_test;
    localparam int OPC  = 4;
    localparam int RLAT = 2;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} row_t;
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_be = 4'hF;
    logic        prot1_n = 1'b1;
    logic        prot2_n = 1'b1;
    logic        sleep_req = 1'b0;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic        avs_waitreq, rst_n, ce_n, oe_n, we_n, wait_v, wait_oe, data_oe, standby;
    int          bad_count = 0;
    int          checked = 0;
    row_t        rows [5];
    always #5 clk = ~clk;
    always #24 link_clk = ~link_clk;
    flash_host_model host (.link_clk_i(link_clk), .rst_n_o(rst_n), .ce_n_o(ce_n),
        .oe_n_o(oe_n), .we_n_o(we_n));
    nor_ctrl_pins #(.OP_CYCLES(OPC), .READ_LAT(RLAT)) dut (.CLK_I(clk), .ARST_N_I(arst_n),
        .LINK_CLK_I(link_clk), .AVS_ADDRESS_I(avs_address), .AVS_READ_I(avs_read),
        .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_writedata), .AVS_BYTEENABLE_I(avs_be),
        .AVS_READDATA_O(avs_readdata), .AVS_WAITREQUEST_O(avs_waitreq),
        .FLASH_RST_N_I(rst_n), .CHIP_EN_N_I(ce_n), .OUT_EN_N_I(oe_n), .WRITE_EN_N_I(we_n),
        .LOCKDOWN_PROTECT_DIE1_N_I(prot1_n), .LOCKDOWN_PROTECT_DIE2_N_I(prot2_n),
        .DEEP_SLEEP_REQUEST_I(sleep_req), .WAIT_O(wait_v), .WAIT_OE_O(wait_oe),
        .DATA_OE_O(data_oe), .STANDBY_O(standby));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitreq !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50)
            bad_count++;
    endtask
    task automatic bit_chk(input logic [7:0] a, input int b, input logic e);
        bus(1'b0, a, 32'h0);
        check(32'(rd[b]), 32'(e));
    endtask
    initial
    begin
        #200000;
        bad_count++;
        give_verdict();
    end
    initial
    begin
        rows[0] = '{nor_pins_pkg::CTRL_OFS, 32'h7, 4'hF, 32'h7};
        rows[1] = '{nor_pins_pkg::CTRL_OFS, 32'h5, 4'h0, 32'h7};
        rows[2] = '{nor_pins_pkg::CTRL_OFS, 32'h0, 4'h1, 32'h0};
        rows[3] = '{8'h10, 32'hFFFFFFFF, 4'hF, 32'h0};
        rows[4] = '{nor_pins_pkg::LOCK_OFS, 32'h3, 4'hF, 32'h3};
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        host.idle(4);
        bus(1'b0, nor_pins_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h18);
        bus(1'b0, nor_pins_pkg::WRCNT_OFS, 32'h0);
        check(rd, 32'h0);
        foreach (rows[i])
        begin
            avs_be <= rows[i].be;
            bus(1'b1, rows[i].a, rows[i].d);
            avs_be <= 4'hF;
            bus(1'b0, rows[i].a, 32'h0);
            check(rd, rows[i].e);
        end
        prot1_n <= 1'b0;
        repeat (6) @(posedge clk);
        bus(1'b1, nor_pins_pkg::LOCK_OFS, 32'h300);
        bit_chk(nor_pins_pkg::STATUS_OFS, nor_pins_pkg::STS_REFUSED_BIT, 1'b1);
        bus(1'b0, nor_pins_pkg::LOCK_OFS, 32'h0);
        check(rd, 32'h1);
        bus(1'b1, nor_pins_pkg::LOCK_OFS, 32'h10000);
        prot1_n <= 1'b1;
        prot2_n <= 1'b0;
        repeat (6) @(posedge clk);
        bit_chk(nor_pins_pkg::STATUS_OFS, nor_pins_pkg::STS_WP2_BIT, 1'b0);
        bus(1'b1, nor_pins_pkg::LOCK_OFS, 32'h100);
        bus(1'b0, nor_pins_pkg::LOCK_OFS, 32'h0);
        check(rd, 32'h0);
        bit_chk(nor_pins_pkg::STATUS_OFS, nor_pins_pkg::STS_REFUSED_BIT, 1'b0);
        // Strobe two hits busy, three is aborted, four falls in reset.
        bus(1'b1, nor_pins_pkg::WRCNT_OFS, 32'h0);
        host.strobe();
        host.strobe();
        host.idle(2 * OPC);
        host.strobe();
        host.drive(1'b0, 1'b1, 1'b1);
        host.idle(2);
        bit_chk(nor_pins_pkg::STATUS_OFS, nor_pins_pkg::STS_IN_RESET_BIT, 1'b1);
        bit_chk(nor_pins_pkg::STATUS_OFS, nor_pins_pkg::STS_BUSY_BIT, 1'b0);
        host.strobe();
        host.drive(1'b0, 1'b0, 1'b0);
        host.idle(4);
        #1;
        check(32'(wait_v), 32'h0);
        host.drive(1'b1, 1'b1, 1'b1);
        host.idle(4);
        bit_chk(nor_pins_pkg::STATUS_OFS, nor_pins_pkg::STS_IN_RESET_BIT, 1'b0);
        bus(1'b0, nor_pins_pkg::WRCNT_OFS, 32'h0);
        check(rd, 32'h00020002);
        for (int p = 0; p < 2; p++)
        begin
            bus(1'b1, nor_pins_pkg::CTRL_OFS, 32'(p));
            host.idle(4);
            host.drive(1'b1, 1'b0, 1'b0);
            host.idle(RLAT + 6);
            #1;
            check(32'(wait_v), 32'(p == 0));
            check({30'h0, wait_oe, data_oe}, 32'h3);
            host.drive(1'b1, 1'b0, 1'b1);
            #1;
            check({30'h0, wait_oe, data_oe}, 32'h0);
            host.drive(1'b1, 1'b1, 1'b1);
            host.idle(1);
            #1;
            check(32'(standby), 32'h1);
        end
        @(posedge clk);
        sleep_req <= 1'b1;
        for (int c = 0; c < 3; c++)
        begin
            bus(1'b1, nor_pins_pkg::CTRL_OFS, (c == 0) ? 32'h6 : (c == 1) ? 32'h2 : 32'h4);
            host.drive(1'b1, 1'b0, 1'b1);
            host.idle(8);
            #1;
            check(32'(standby), 32'(c == 0));
            bit_chk(nor_pins_pkg::STATUS_OFS, nor_pins_pkg::STS_SLEEP_BIT, c == 0);
            host.drive(1'b1, 1'b1, 1'b1);
        end
        give_verdict();
    end
endmodule
bind nor_ctrl_pins nor_ctrl_pins_monitor mon (.*);
`default_nettype wire
